// >>> rtl/cis_core.sv
// Execution core for the call, register and literal instruction subset
//
// Summary of operation
// RL1 - A call pushes the address after the call (program counter plus one) onto the stack top.
// RL2 - A call loads its 11-bit target into program counter bits 10 to 0.
// RL3 - A call copies latch bits 4 and 3 into program counter bits 12 and 11.
// RL4 - A call takes two instruction cycles and leaves every status flag alone.
// RL5 - Complement inverts the file register, writes the destination and updates zero.
// RL6 - A destination bit of 0 writes the working register, 1 writes the file register.
// RL7 - Clear register writes 00h into the file register and sets zero.
// RL8 - Clear working loads 00h into the working register and sets zero.
// RL9 - Decrement subtracts one from the file register into the destination, updating zero.
// RL10 - Move register copies the file register to the chosen destination in one cycle.
// RL11 - Move register updates zero from the moved value, so a write-back only tests it.
// RL12 - Store working copies the working register into the file register, flags untouched.
// RL13 - Load literal places its 8-bit literal in the working register, flags untouched.
// RL14 - No operation takes one cycle and only advances the program counter.
// RL15 - File operands use a 7-bit address, locations 0 to 127 of the current bank.
`include "cis_cfg.svh"

module cis_core
  import cis_pkg::*;
(
  input wire logic clk, // System clock, 25 MHz
  input wire logic reset_n, // Core reset, active low, asynchronous
  input wire logic [`CIS_INSTR_W-1:0] instr, // Fetched instruction word
  input wire logic instr_valid, // Instruction word present
  output logic instr_ready, // Core takes a word this cycle
  input wire logic [`CIS_DATA_W-1:0] program_counter_high_latch, // Upper address latch
  output logic [`CIS_PC_W-1:0] program_counter, // Address of next fetch
  output logic [`CIS_PC_W-1:0] stack_top_entry, // Last pushed return address
  output logic stack_push, // Return address pushed, one cycle
  output logic [`CIS_DATA_W-1:0] working_reg, // Working register
  output logic zero_flag, // Zero status flag
  output logic retired, // Instruction finished, one cycle
  output logic illegal_op, // Word outside the subset, one cycle
  input wire logic [`CIS_FADDR_W-1:0] peek_addr, // File inspection address
  output logic [`CIS_DATA_W-1:0] peek_data // File inspection data
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  // Two stage release of the asynchronous reset
  // Assertion is immediate, release waits two edges to avoid metastability
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  cis_op_t op;
  logic dest_file;
  logic [`CIS_FADDR_W-1:0] faddr;
  logic [`CIS_CALL_K_W-1:0] call_k;
  logic [`CIS_DATA_W-1:0] literal;

  cis_decode u_decode (
    .instr(instr),
    .op(op),
    .dest_file(dest_file),
    .faddr(faddr),
    .call_k(call_k),
    .literal(literal)
  );

  ////////////////////////////////////////////////////////////////////////////
  // File registers

  logic [`CIS_DATA_W-1:0] file_rd;
  logic file_we;
  logic [`CIS_DATA_W-1:0] file_wd;

  cis_regfile u_regfile (
    .clk(clk),
    .rst_n(rst_n),
    .rd_addr(faddr),
    .rd_data(file_rd),
    .wr_en(file_we),
    .wr_addr(faddr),
    .wr_data(file_wd),
    .peek_addr(peek_addr),
    .peek_data(peek_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  cis_state_t state_reg;
  cis_state_t state_next;
  logic [`CIS_PC_W-1:0] pc_reg;
  logic [`CIS_PC_W-1:0] pc_next;
  // Single return address entry, an outside stack follows the push pulse
  logic [`CIS_PC_W-1:0] stack_top_reg;
  logic [`CIS_PC_W-1:0] stack_top_next;
  logic push_reg;
  logic push_next;
  logic [`CIS_DATA_W-1:0] w_reg;
  logic [`CIS_DATA_W-1:0] w_next;
  logic z_reg;
  logic z_next;
  logic retired_reg;
  logic retired_next;
  logic illegal_reg;
  logic illegal_next;

  // Working values for the current instruction
  logic take;
  logic [`CIS_PC_W-1:0] pc_inc;
  logic [`CIS_DATA_W-1:0] alu_res;
  logic alu_zero_upd;
  logic alu_has_res;

  // Accept a word only in the execute phase
  // Ready drops for the second call cycle, a word offered then is ignored
  assign take = instr_valid && (state_reg == CIS_ST_EXEC);
  assign instr_ready = (state_reg == CIS_ST_EXEC); // RL4
  assign pc_inc = pc_reg + `CIS_PC_W'(1);

  ////////////////////////////////////////////////////////////////////////////
  // Result path

  // Result value and whether zero follows it
  always_comb begin
    alu_res = `CIS_CLEAR_VALUE;
    alu_zero_upd = 1'b0;
    alu_has_res = 1'b0;
    case (op)
      CIS_OP_COMPL: begin
        alu_res = ~file_rd; // RL5
        alu_zero_upd = 1'b1;
        alu_has_res = 1'b1;
      end
      CIS_OP_DEC: begin
        // Wraps from 00h to ffh, zero then clear
        alu_res = file_rd - `CIS_DATA_W'(1); // RL9
        alu_zero_upd = 1'b1;
        alu_has_res = 1'b1;
      end
      CIS_OP_MOVE: begin
        // Write-back of the same value only tests it
        alu_res = file_rd; // RL10
        alu_zero_upd = 1'b1; // RL11
        alu_has_res = 1'b1;
      end
      default: begin
        alu_res = `CIS_CLEAR_VALUE;
      end
    endcase
  end

  // File write strobe and data
  always_comb begin
    file_we = 1'b0;
    file_wd = alu_res;
    if (take) begin
      case (op)
        CIS_OP_CLEAR_REG: begin
          file_we = 1'b1;
          file_wd = `CIS_CLEAR_VALUE; // RL7
        end
        CIS_OP_STORE_W: begin
          file_we = 1'b1;
          file_wd = w_reg; // RL12
        end
        default: begin
          file_we = alu_has_res && dest_file; // RL6
          file_wd = alu_res;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing, program counter, stack, working register and flag

  // Next state of the core
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    stack_top_next = stack_top_reg;
    push_next = 1'b0;
    w_next = w_reg;
    z_next = z_reg;
    retired_next = 1'b0;
    illegal_next = 1'b0;
    case (state_reg)
      CIS_ST_EXEC: begin
        if (take) begin
          pc_next = pc_inc;
          retired_next = 1'b1;
          case (op)
            CIS_OP_CALL: begin
              // Return address taken before the counter is redirected
              stack_top_next = pc_inc; // RL1
              push_next = 1'b1; // RL1
              pc_next = {program_counter_high_latch[`CIS_LATCH_HI_BIT:`CIS_LATCH_LO_BIT],
                         call_k}; // RL2 RL3
              retired_next = 1'b0;
              state_next = CIS_ST_CALL2; // RL4
            end
            // Register operations with a destination bit
            CIS_OP_COMPL,
            CIS_OP_DEC,
            CIS_OP_MOVE: begin
              if (!dest_file) begin
                w_next = alu_res; // RL6
              end
              if (alu_zero_upd) begin
                z_next = (alu_res == `CIS_CLEAR_VALUE); // RL5 RL9 RL11
              end
            end
            // File write for the clear is done by the strobe logic
            CIS_OP_CLEAR_REG: begin
              z_next = 1'b1; // RL7
            end
            CIS_OP_CLEAR_W: begin
              w_next = `CIS_CLEAR_VALUE; // RL8
              z_next = 1'b1; // RL8
            end
            // Store keeps the flag, the file write is done by the strobe logic
            CIS_OP_STORE_W: begin
              z_next = z_reg; // RL12
            end
            // Literal load leaves the flag as it stands
            CIS_OP_LOAD_LIT: begin
              w_next = literal; // RL13
            end
            CIS_OP_NOP: begin
              pc_next = pc_inc; // RL14
            end
            // Words outside the subset step on as a no operation and pulse the illegal flag
            default: begin
              illegal_next = 1'b1;
            end
          endcase
        end
      end
      CIS_ST_CALL2: begin
        // Second cycle of a call, fetch slot discarded
        retired_next = 1'b1; // RL4
        state_next = CIS_ST_EXEC;
      end
      default: begin
        state_next = CIS_ST_EXEC;
      end
    endcase
  end

  // Core registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CIS_ST_EXEC;
      pc_reg <= `CIS_PC_RESET;
      stack_top_reg <= `CIS_PC_RESET;
      push_reg <= 1'b0;
      w_reg <= `CIS_W_RESET;
      z_reg <= `CIS_Z_RESET;
      retired_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      stack_top_reg <= stack_top_next;
      push_reg <= push_next;
      w_reg <= w_next;
      z_reg <= z_next;
      retired_reg <= retired_next;
      illegal_reg <= illegal_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // All data outputs straight from flip-flops
  assign program_counter = pc_reg;
  // Pulses last one cycle, data holds until the next instruction
  assign stack_top_entry = stack_top_reg;
  assign stack_push = push_reg;
  assign working_reg = w_reg;
  assign zero_flag = z_reg;
  assign retired = retired_reg;
  assign illegal_op = illegal_reg;

endmodule

// >>> shared/cis_cfg.svh
// Constants for the instruction subset execution block
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH

// Widths
`define CIS_INSTR_W 14
`define CIS_PC_W 13
`define CIS_DATA_W 8
`define CIS_FADDR_W 7
`define CIS_CALL_K_W 11
`define CIS_FILE_DEPTH 128

// Field positions inside an instruction word and the upper address latch
`define CIS_DEST_BIT 7
`define CIS_LATCH_HI_BIT 4
`define CIS_LATCH_LO_BIT 3

// Opcode patterns, compared under the masks below
`define CIS_MASK_CALL 14'h3800
`define CIS_CODE_CALL 14'h2000
`define CIS_MASK_BYTE 14'h3f00
`define CIS_CODE_COMPL 14'h0900
`define CIS_CODE_DEC 14'h0300
`define CIS_CODE_MOVE 14'h0800
`define CIS_MASK_CLR 14'h3f80
`define CIS_CODE_CLEAR_REG 14'h0180
`define CIS_CODE_CLEAR_W 14'h0100
`define CIS_CODE_STORE_W 14'h0080
`define CIS_MASK_LIT 14'h3c00
`define CIS_CODE_LOAD_LIT 14'h3000
`define CIS_MASK_NOP 14'h3f9f
`define CIS_CODE_NOP 14'h0000

// Reset values
`define CIS_PC_RESET 13'h0000
`define CIS_W_RESET 8'h00
`define CIS_Z_RESET 1'b0
`define CIS_CLEAR_VALUE 8'h00

`endif

// >>> shared/cis_pkg.sv
// Types shared by the instruction subset execution block
package cis_pkg;

  // Decoded operation
  typedef enum logic [3:0] {
    CIS_OP_NONE,
    CIS_OP_CALL,
    CIS_OP_COMPL,
    CIS_OP_CLEAR_REG,
    CIS_OP_CLEAR_W,
    CIS_OP_DEC,
    CIS_OP_MOVE,
    CIS_OP_STORE_W,
    CIS_OP_LOAD_LIT,
    CIS_OP_NOP
  } cis_op_t;

  // Execution phase of the core
  typedef enum logic {
    CIS_ST_EXEC,
    CIS_ST_CALL2
  } cis_state_t;

endpackage

// >>> rtl/cis_decode.sv
// Instruction word decoder for the execution subset
`include "cis_cfg.svh"

module cis_decode
  import cis_pkg::*;
(
  input wire logic [`CIS_INSTR_W-1:0] instr, // Instruction word
  output cis_op_t op, // Decoded operation
  output logic dest_file, // Destination select bit
  output logic [`CIS_FADDR_W-1:0] faddr, // File register address
  output logic [`CIS_CALL_K_W-1:0] call_k, // Call target
  output logic [`CIS_DATA_W-1:0] literal // Literal operand
);

  // Operand fields
  assign dest_file = instr[`CIS_DEST_BIT];
  assign faddr = instr[`CIS_FADDR_W-1:0]; // RL15
  assign call_k = instr[`CIS_CALL_K_W-1:0];
  assign literal = instr[`CIS_DATA_W-1:0];

  // Opcode match, unknown words fall to none
  always_comb begin
    op = CIS_OP_NONE;
    if ((instr & `CIS_MASK_CALL) == `CIS_CODE_CALL) begin
      op = CIS_OP_CALL;
    end else if ((instr & `CIS_MASK_BYTE) == `CIS_CODE_COMPL) begin
      op = CIS_OP_COMPL;
    end else if ((instr & `CIS_MASK_BYTE) == `CIS_CODE_DEC) begin
      op = CIS_OP_DEC;
    end else if ((instr & `CIS_MASK_BYTE) == `CIS_CODE_MOVE) begin
      op = CIS_OP_MOVE;
    end else if ((instr & `CIS_MASK_CLR) == `CIS_CODE_CLEAR_REG) begin
      op = CIS_OP_CLEAR_REG;
    end else if ((instr & `CIS_MASK_CLR) == `CIS_CODE_CLEAR_W) begin
      op = CIS_OP_CLEAR_W;
    end else if ((instr & `CIS_MASK_CLR) == `CIS_CODE_STORE_W) begin
      op = CIS_OP_STORE_W;
    end else if ((instr & `CIS_MASK_LIT) == `CIS_CODE_LOAD_LIT) begin
      op = CIS_OP_LOAD_LIT;
    end else if ((instr & `CIS_MASK_NOP) == `CIS_CODE_NOP) begin
      op = CIS_OP_NOP;
    end
  end

endmodule

// >>> rtl/cis_regfile.sv
// File register array with one execute port and one inspection port
`include "cis_cfg.svh"

module cis_regfile
  import cis_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic [`CIS_FADDR_W-1:0] rd_addr, // Operand read address
  output logic [`CIS_DATA_W-1:0] rd_data, // Operand read data
  input wire logic wr_en, // Write strobe
  input wire logic [`CIS_FADDR_W-1:0] wr_addr, // Write address
  input wire logic [`CIS_DATA_W-1:0] wr_data, // Write data
  input wire logic [`CIS_FADDR_W-1:0] peek_addr, // Inspection address
  output logic [`CIS_DATA_W-1:0] peek_data // Inspection data, registered
);

  logic [`CIS_DATA_W-1:0] mem_reg [`CIS_FILE_DEPTH];
  logic [`CIS_DATA_W-1:0] mem_next [`CIS_FILE_DEPTH];
  logic [`CIS_DATA_W-1:0] peek_reg;
  logic [`CIS_DATA_W-1:0] peek_next;

  // Operand read, combinational
  assign rd_data = mem_reg[rd_addr];
  assign peek_data = peek_reg;

  // Per entry write decode
  genvar i;
  generate
    for (i = 0; i < `CIS_FILE_DEPTH; i++) begin : g_entry
      always_comb begin
        mem_next[i] = mem_reg[i];
        if (wr_en && (wr_addr == `CIS_FADDR_W'(i))) begin
          mem_next[i] = wr_data;
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_reg[i] <= `CIS_CLEAR_VALUE;
        end else begin
          mem_reg[i] <= mem_next[i];
        end
      end
    end
  endgenerate

  // Inspection read shows the value after this edge's write
  always_comb begin
    peek_next = mem_next[peek_addr];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      peek_reg <= `CIS_CLEAR_VALUE;
    end else begin
      peek_reg <= peek_next;
    end
  end

endmodule

// >>> tb/cis_core_asserts.sv
// Checker for the execution core ports
`include "cis_cfg.svh"

module cis_core_asserts
  import cis_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic [`CIS_INSTR_W-1:0] instr, // Word
  input wire logic instr_valid, // Valid
  input wire logic instr_ready, // Ready
  input wire logic [`CIS_DATA_W-1:0] program_counter_high_latch, // Latch
  input wire logic [`CIS_PC_W-1:0] program_counter, // Counter
  input wire logic [`CIS_PC_W-1:0] stack_top_entry, // Stack top
  input wire logic stack_push, // Push pulse
  input wire logic [`CIS_DATA_W-1:0] working_reg, // Working
  input wire logic zero_flag, // Zero
  input wire logic retired, // Done pulse
  input wire logic illegal_op, // Illegal pulse
  input wire logic [`CIS_FADDR_W-1:0] peek_addr, // Peek address
  input wire logic [`CIS_DATA_W-1:0] peek_data // Peek data
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // Taken words by kind
  logic take, call, clear_working, lit, no_operation, stw;
  assign take = instr_valid && instr_ready;
  assign call = take && ((instr & `CIS_MASK_CALL) == `CIS_CODE_CALL);
  assign clear_working = take && ((instr & `CIS_MASK_CLR) == `CIS_CODE_CLEAR_W);
  assign lit = take && ((instr & `CIS_MASK_LIT) == `CIS_CODE_LOAD_LIT);
  assign no_operation = take && ((instr & `CIS_MASK_NOP) == `CIS_CODE_NOP);
  assign stw = take && ((instr & `CIS_MASK_CLR) == `CIS_CODE_STORE_W);

  ////////////////////////////////////////////////////////////////////////////
  // Properties
  call_target_a: assert property (call |=> program_counter ==
    {$past(program_counter_high_latch[4:3]), $past(instr[10:0])})
    else $error("call target wrong");
  call_push_a: assert property (call |=> stack_push &&
    stack_top_entry == $past(program_counter) + 13'h1)
    else $error("return address wrong");
  call_cycles_a: assert property (call |=> !instr_ready ##1
    (instr_ready && retired && !stack_push))
    else $error("call length wrong");
  call_flags_a: assert property (call |=>
    ($stable(zero_flag) && $stable(working_reg)) [*2])
    else $error("call touched flags");
  one_cycle_a: assert property (take && !call |=> retired &&
    instr_ready && program_counter == $past(program_counter) + 13'h1)
    else $error("single cycle step wrong");
  clear_work_a: assert property (clear_working |=> working_reg == 8'h00 && zero_flag)
    else $error("clear working wrong");
  literal_load_a: assert property (lit |=>
    working_reg == $past(instr[7:0]) && $stable(zero_flag))
    else $error("literal load wrong");
  store_keep_a: assert property (stw |=> $stable(zero_flag) && $stable(working_reg))
    else $error("store changed flags");
  nop_keep_a: assert property (no_operation |=> $stable(working_reg) && $stable(zero_flag))
    else $error("no operation changed state");
endmodule

bind cis_core cis_core_asserts i_chk (.clk, .reset_n, .instr, .instr_valid,
  .instr_ready, .program_counter_high_latch, .program_counter, .stack_top_entry,
  .stack_push, .working_reg, .zero_flag, .retired, .illegal_op, .peek_addr,
  .peek_data);

// >>> tb/cis_core_tb.sv
// Self-checking bench for the execution core
`include "cis_cfg.svh"

module cis_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic instr_valid = 1'b0;
  logic [7:0] program_counter_high_latch = 8'h00;
  logic [6:0] peek_addr = 7'h00;
  logic instr_ready, stack_push, zero_flag, retired, illegal_op;
  logic [12:0] program_counter, stack_top_entry;
  logic [7:0] working_reg, peek_data;
  logic [12:0] m_pc = 13'h0000;
  int failures = 0;
  int num_checks = 0;

  // Clock and device
  always #20 clk = ~clk;
  cis_core i_dut (.clk, .reset_n, .instr, .instr_valid, .instr_ready,
    .program_counter_high_latch, .program_counter, .stack_top_entry, .stack_push,
    .working_reg, .zero_flag, .retired, .illegal_op, .peek_addr, .peek_data);

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [13:0] fop(input logic [13:0] c, input logic d,
    input logic [6:0] f);
    return c | {6'h00, d, f};
  endfunction

  // Offer a word, return just after its take edge, valid left high
  task automatic issue(input logic [13:0] w);
    int n;
    n = 0;
    instr = w;
    instr_valid = 1'b1;
    while (instr_ready !== 1'b1) begin
      n++;
      if (n > 8) begin
        failures++;
        summarize();
      end
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    if ((w & `CIS_MASK_CALL) == `CIS_CODE_CALL) begin
      check(stack_top_entry, m_pc + 13'h1);
      m_pc = {program_counter_high_latch[4:3], w[10:0]};
    end else begin
      m_pc = m_pc + 13'h1;
      check(retired, 1'b1);
    end
    check(program_counter, m_pc);
  endtask

  task automatic peek(input logic [6:0] a, input logic [7:0] exp);
    instr_valid = 1'b0;
    peek_addr = a;
    @(posedge clk);
    #1;
    check(peek_data, exp);
  endtask

  task automatic wz(input logic [7:0] w, input logic z);
    check(working_reg, w);
    check(zero_flag, z);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic s_reset();
    instr_valid = 1'b0;
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    m_pc = 13'h0000;
    repeat (2) @(posedge clk);
    #1;
    check(program_counter, 13'h0000);
    check(instr_ready, 1'b1);
    wz(8'h00, 1'b0);
    peek(7'h7f, 8'h00);
  endtask

  task automatic s_literal_store();
    issue(`CIS_CODE_LOAD_LIT | 14'h00a5);
    wz(8'ha5, 1'b0);
    issue(`CIS_CODE_LOAD_LIT | 14'h0000);
    wz(8'h00, 1'b0);
    issue(`CIS_CODE_LOAD_LIT | 14'h005a);
    issue(fop(`CIS_CODE_STORE_W, 1'b0, 7'h7f));
    wz(8'h5a, 1'b0);
    issue(`CIS_CODE_LOAD_LIT | 14'h00ff);
    issue(fop(`CIS_CODE_STORE_W, 1'b0, 7'h10));
    peek(7'h7f, 8'h5a);
    peek(7'h10, 8'hff);
  endtask

  task automatic s_complement();
    issue(fop(`CIS_CODE_COMPL, 1'b1, 7'h7f));
    wz(8'hff, 1'b0);
    issue(fop(`CIS_CODE_COMPL, 1'b0, 7'h10));
    wz(8'h00, 1'b1);
    peek(7'h7f, 8'ha5);
    peek(7'h10, 8'hff);
  endtask

  task automatic s_decrement();
    issue(`CIS_CODE_LOAD_LIT | 14'h0001);
    issue(fop(`CIS_CODE_STORE_W, 1'b0, 7'h20));
    issue(fop(`CIS_CODE_DEC, 1'b1, 7'h20));
    wz(8'h01, 1'b1);
    issue(fop(`CIS_CODE_DEC, 1'b0, 7'h20));
    wz(8'hff, 1'b0);
    peek(7'h20, 8'h00);
  endtask

  task automatic s_move_clear();
    issue(fop(`CIS_CODE_MOVE, 1'b1, 7'h20));
    wz(8'hff, 1'b1);
    issue(fop(`CIS_CODE_MOVE, 1'b0, 7'h7f));
    wz(8'ha5, 1'b0);
    peek(7'h20, 8'h00);
    issue(fop(`CIS_CODE_CLEAR_REG, 1'b0, 7'h7f));
    wz(8'ha5, 1'b1);
    peek(7'h7f, 8'h00);
    issue(fop(`CIS_CODE_MOVE, 1'b0, 7'h10));
    wz(8'hff, 1'b0);
    issue(`CIS_CODE_CLEAR_W);
    wz(8'h00, 1'b1);
  endtask

  task automatic s_call();
    program_counter_high_latch = 8'h18;
    issue(`CIS_CODE_CALL | 14'h07ff);
    check(stack_push, 1'b1);
    check(instr_ready, 1'b0);
    wz(8'h00, 1'b1);
    issue(fop(`CIS_CODE_DEC, 1'b1, 7'h20));
    peek(7'h20, 8'hff);
    issue(14'h0060);
    wz(8'h00, 1'b0);
    program_counter_high_latch = 8'he7;
    issue(`CIS_CODE_CALL | 14'h0001);
    program_counter_high_latch = 8'h08;
    issue(`CIS_CODE_CALL | 14'h0400);
    issue(14'h3fff);
    check(illegal_op, 1'b1);
    wz(8'h00, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    s_reset();
    s_literal_store();
    s_complement();
    s_decrement();
    s_move_clear();
    s_call();
    s_reset();
    summarize();
  end
endmodule
